// ===== common/sp_pkg.sv
/*
  Constants, register map and carrier types of the parallel slave port.
  Assumes a 32-bit AXI4-Lite register bus; byte address is four times the index.
*/
package sp_pkg;

  localparam int SP_ADDR_W = 12;
  localparam int SP_IDX_W = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] SP_IDX_DATA = 8'h08;
  localparam logic [7:0] SP_IDX_PINS = 8'h09;
  localparam logic [7:0] SP_IDX_FLAGS = 8'h0c;
  localparam logic [7:0] SP_IDX_DIR_D = 8'h88;
  localparam logic [7:0] SP_IDX_CTRL = 8'h89;
  localparam logic [7:0] SP_IDX_EN = 8'h8c;
  localparam logic [7:0] SP_IDX_IRQ_STAT = 8'h90;
  localparam logic [7:0] SP_IDX_IRQ_MASK = 8'h91;

  // Field positions of port_e_control, periph_flags and periph_enables.
  localparam int SP_CTRL_IBF = 7;
  localparam int SP_CTRL_OBF = 6;
  localparam int SP_CTRL_IN_BUF_OVERFLOW = 5;
  localparam int SP_CTRL_MODE = 4;
  localparam int SP_FLAG_IRQ = 7;
  localparam int SP_EN_IRQ = 7;

  // Event bits of the interrupt status and mask registers.
  localparam int SP_IRQ_W = 3;
  localparam int SP_EV_RD = 0;
  localparam int SP_EV_WR = 1;
  localparam int SP_EV_OVF = 2;

  localparam logic [2:0] SP_TRIS_E_RST = 3'h7;
  localparam logic [7:0] SP_DIR_D_RST = 8'hff;
  localparam logic [1:0] SP_RESP_OKAY = 2'h0;
  localparam logic [1:0] SP_RESP_SLVERR = 2'h2;

  // Port E pins as seen by the slave port: pin 2 select, pin 1 write, pin 0 read.
  typedef struct packed {
    logic cs;
    logic wr;
    logic rd;
  } sp_strobe_t;

endpackage : sp_pkg

// ===== src/sp_slave_port.sv
/*
  Parallel slave port on port D with port E strobes, AXI4-Lite register slave.
  Assumes external pins are asynchronous to core_clk and strobes stay low for
  at least three clock periods; the testbench resolves the pin wires.
*/
`timescale 1ns/100ps
`default_nettype none
module sp_slave_port #(
  parameter int ADDR_W = sp_pkg::SP_ADDR_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] portDIn,
  output logic [7:0] portDOut,
  output logic [7:0] portDOen,
  input wire logic [2:0] portEIn,
  output logic [2:0] portEOut,
  output logic [2:0] portEOen,
  output logic irq
);

  logic [7:0] pdSync1, pdSync2, pdSync3, pdStable;
  logic [2:0] peSync1, peSync2, peSync3, peStable;
  sp_pkg::sp_strobe_t strb;
  logic strobesOk, rdAct, wrAct, rdActQ, wrActQ, rdDone, wrDone, ovfSet;
  logic [7:0] outLatch, inLatch, wrShadow, dirD;
  logic [2:0] peLatch, port_e_control;
  localparam int SP_IRQ_W_L = sp_pkg::SP_IRQ_W;

  logic mode, in_buf_full, out_buf_full, in_buf_overflow, slave_port_irq_flag, slave_port_irq_enable, driveReg;
  logic [SP_IRQ_W_L-1:0] irqStat, irqMask;
  logic bvalidReg, rvalidReg;
  logic [1:0] brespReg, rrespReg;
  logic [31:0] rdataReg;
  logic wrFire, rdFire, wEn, wMapped, rMapped, cpuWrData, cpuRdData;
  logic [7:0] wIdx, rIdx, rdMux;

  // Three-stage synchronisers; only the second stage reads the first.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pdSync1 <= 8'h00;
      pdSync2 <= 8'h00;
      pdSync3 <= 8'h00;
      peSync1 <= 3'h7;
      peSync2 <= 3'h7;
      peSync3 <= 3'h7;
    end else begin
      pdSync1 <= portDIn;
      pdSync2 <= pdSync1;
      pdSync3 <= pdSync2;
      peSync1 <= portEIn;
      peSync2 <= peSync1;
      peSync3 <= peSync2;
    end
  end

  // A bit changes only once the last two stages agree, which rejects glitches.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pdStable <= 8'h00;
      peStable <= 3'h7;
    end else begin
      pdStable <= (pdSync3 & ~(pdSync2 ^ pdSync3)) | (pdStable & (pdSync2 ^ pdSync3));
      peStable <= (peSync3 & ~(peSync2 ^ peSync3)) | (peStable & (peSync2 ^ peSync3));
    end
  end

  // Strobe decode; the select pin must be low for either strobe to count.
  assign strb = sp_pkg::sp_strobe_t'(peStable);
  assign strobesOk = mode & (&port_e_control);
  assign rdAct = strobesOk & ~strb.cs & ~strb.rd;
  assign wrAct = strobesOk & ~strb.cs & ~strb.wr;

  // Last cycle's strobe activity, kept to find the release edge.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdActQ <= 1'b0;
      wrActQ <= 1'b0;
    end else begin
      rdActQ <= rdAct;
      wrActQ <= wrAct;
    end
  end

  // A transfer completes on the release of its strobe, seen as a falling active.
  assign rdDone = rdActQ & ~rdAct & strobesOk;
  assign wrDone = wrActQ & ~wrAct & strobesOk;
  assign ovfSet = wrDone & in_buf_full;

  // The data bus is tracked while the strobe is low so the last value before
  // release is kept; the pins may already change once the strobe rises.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrShadow <= 8'h00;
    end else if (wrAct) begin
      wrShadow <= pdStable;
    end
  end

  // Incoming latch; a word that is still unread is never overwritten.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      inLatch <= 8'h00;
    end else if (wrDone && !in_buf_full) begin
      inLatch <= wrShadow;
    end
  end

  // AXI4-Lite handshakes: address and data are taken together, one of each at a time.
  assign wrFire = s_axi_awvalid & s_axi_wvalid & ~bvalidReg;
  assign rdFire = s_axi_arvalid & ~rvalidReg;
  assign s_axi_awready = wrFire;
  assign s_axi_wready = wrFire;
  assign s_axi_arready = ~rvalidReg;
  assign wIdx = s_axi_awaddr[9:2];
  assign rIdx = s_axi_araddr[9:2];
  assign wEn = wrFire & s_axi_wstrb[0] & wMapped;
  assign cpuWrData = wEn & (wIdx == sp_pkg::SP_IDX_DATA);
  assign cpuRdData = rdFire & (rIdx == sp_pkg::SP_IDX_DATA) & mode;

  // Write decode; only the low byte lane holds register bits.
  always_comb begin
    wMapped = (s_axi_awaddr >> 10) == '0;
    if (wMapped) begin
      unique case (wIdx)
        sp_pkg::SP_IDX_DATA, sp_pkg::SP_IDX_PINS, sp_pkg::SP_IDX_FLAGS,
        sp_pkg::SP_IDX_DIR_D, sp_pkg::SP_IDX_CTRL, sp_pkg::SP_IDX_EN,
        sp_pkg::SP_IDX_IRQ_STAT, sp_pkg::SP_IDX_IRQ_MASK: wMapped = 1'b1;
        default: wMapped = 1'b0;
      endcase
    end
  end

  // Outgoing latch and general-purpose latches; CPU writes land at the edge
  // that takes address and data, the same edge that raises the response.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      outLatch <= 8'h00;
      peLatch <= 3'h0;
      dirD <= sp_pkg::SP_DIR_D_RST;
      port_e_control <= sp_pkg::SP_TRIS_E_RST;
      mode <= 1'b0;
      slave_port_irq_enable <= 1'b0;
      irqMask <= '0;
    end else if (wEn) begin
      unique case (wIdx)
        sp_pkg::SP_IDX_DATA: outLatch <= s_axi_wdata[7:0];
        sp_pkg::SP_IDX_PINS: peLatch <= s_axi_wdata[2:0];
        sp_pkg::SP_IDX_DIR_D: dirD <= s_axi_wdata[7:0];
        sp_pkg::SP_IDX_CTRL: begin
          mode <= s_axi_wdata[sp_pkg::SP_CTRL_MODE];
          port_e_control <= s_axi_wdata[2:0];
        end
        sp_pkg::SP_IDX_EN: slave_port_irq_enable <= s_axi_wdata[sp_pkg::SP_EN_IRQ];
        sp_pkg::SP_IDX_IRQ_MASK: irqMask <= s_axi_wdata[SP_IRQ_W_L-1:0];
        default: ;
      endcase
    end
  end

  // Buffer flags; a set, by hardware or by the CPU, wins over a clear in the same cycle.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_buf_full <= 1'b0;
      out_buf_full <= 1'b0;
    end else if (!mode) begin
      in_buf_full <= 1'b0;
      out_buf_full <= 1'b0;
    end else begin
      if (wrDone) begin
        in_buf_full <= 1'b1;
      end else if (cpuRdData) begin
        in_buf_full <= 1'b0;
      end
      if (cpuWrData) begin
        out_buf_full <= 1'b1;
      end else if (rdDone) begin
        out_buf_full <= 1'b0;
      end
    end
  end

  // Overflow survives leaving slave mode; software may only clear it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_buf_overflow <= 1'b0;
    end else if (ovfSet) begin
      in_buf_overflow <= 1'b1;
    end else if (wEn && wIdx == sp_pkg::SP_IDX_CTRL && !s_axi_wdata[sp_pkg::SP_CTRL_IN_BUF_OVERFLOW]) begin
      in_buf_overflow <= 1'b0;
    end
  end

  // Sticky transfer flag; set by a transfer, otherwise only a write to periph_flags changes it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slave_port_irq_flag <= 1'b0;
    end else if (rdDone || wrDone) begin
      slave_port_irq_flag <= 1'b1;
    end else if (wEn && wIdx == sp_pkg::SP_IDX_FLAGS) begin
      slave_port_irq_flag <= s_axi_wdata[sp_pkg::SP_FLAG_IRQ];
    end
  end

  // Event status cleared by reading it; an event in the same cycle survives.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irqStat <= '0;
    end else begin
      irqStat <= (irqStat & ~{SP_IRQ_W_L{rdFire && rMapped && rIdx == sp_pkg::SP_IDX_IRQ_STAT}})
        | {ovfSet, wrDone, rdDone};
    end
  end

  // The level request combines the gated transfer flag with the masked events.
  // It is built from flops only, so a pin change cannot make it glitch.
  assign irq = (slave_port_irq_flag & slave_port_irq_enable) | (|(irqStat & irqMask));

  // In slave mode the data pins drive one cycle behind an external read, from a registered copy of its strobe.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      driveReg <= 1'b0;
    end else begin
      driveReg <= rdAct;
    end
  end

  assign portDOut = outLatch;
  assign portDOen = mode ? {8{~driveReg}} : dirD;
  assign portEOut = peLatch;
  assign portEOen = port_e_control;

  // Read mux; CPU reads see the state at the start of the bus cycle.
  always_comb begin
    rdMux = 8'h00;
    rMapped = (s_axi_araddr >> 10) == '0;
    if (rMapped) begin
      unique case (rIdx)
        sp_pkg::SP_IDX_DATA: rdMux = mode ? inLatch : pdStable;
        sp_pkg::SP_IDX_PINS: rdMux = {5'h00, peStable};
        sp_pkg::SP_IDX_FLAGS: rdMux = {slave_port_irq_flag, 7'h00};
        sp_pkg::SP_IDX_DIR_D: rdMux = dirD;
        sp_pkg::SP_IDX_CTRL: rdMux = {in_buf_full, out_buf_full, in_buf_overflow, mode, 1'b0, port_e_control};
        sp_pkg::SP_IDX_EN: rdMux = {slave_port_irq_enable, 7'h00};
        sp_pkg::SP_IDX_IRQ_STAT: rdMux = {5'h00, irqStat};
        sp_pkg::SP_IDX_IRQ_MASK: rdMux = {5'h00, irqMask};
        default: rMapped = 1'b0;
      endcase
    end
  end

  // Responses are held until the master accepts them.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bvalidReg <= 1'b0;
      brespReg <= sp_pkg::SP_RESP_OKAY;
    end else if (wrFire) begin
      bvalidReg <= 1'b1;
      brespReg <= wMapped ? sp_pkg::SP_RESP_OKAY : sp_pkg::SP_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalidReg <= 1'b0;
    end
  end

  // Read data are captured at the taking edge, so the word shows the state before it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rvalidReg <= 1'b0;
      rrespReg <= sp_pkg::SP_RESP_OKAY;
      rdataReg <= 32'h0000_0000;
    end else if (rdFire) begin
      rvalidReg <= 1'b1;
      rrespReg <= rMapped ? sp_pkg::SP_RESP_OKAY : sp_pkg::SP_RESP_SLVERR;
      rdataReg <= {24'h00_0000, rdMux};
    end else if (s_axi_rready) begin
      rvalidReg <= 1'b0;
    end
  end

  // Every response output comes straight from a flop.
  assign s_axi_bvalid = bvalidReg;
  assign s_axi_bresp = brespReg;
  assign s_axi_rvalid = rvalidReg;
  assign s_axi_rresp = rrespReg;
  assign s_axi_rdata = rdataReg;

  // Checks on flag behaviour and pin drive.
  default clocking spCb @(posedge core_clk); endclocking
  default disable iff (rst);

  ibf_set_a: assert property (wrDone |=> in_buf_full || !mode) else $error("ibf not set");
  ibf_clear_a: assert property (cpuRdData && !wrDone && in_buf_full |=> !in_buf_full) else $error("ibf kept");
  obf_set_a: assert property (cpuWrData && mode |=> out_buf_full || !mode) else $error("obf not set");
  obf_clear_a: assert property (rdDone && !cpuWrData |=> !out_buf_full) else $error("obf kept");
  ovf_keep_a: assert property (wrDone && in_buf_full |=> in_buf_overflow && $stable(inLatch)) else $error("ovf bad");
  flags_off_a: assert property (!$past(mode) && !mode |-> !in_buf_full && !out_buf_full) else $error("flags set");
  irqflag_set_a: assert property (rdDone || wrDone |=> slave_port_irq_flag) else $error("flag not set");
  irqflag_hold_a: assert property (
    slave_port_irq_flag && !(wEn && wIdx == sp_pkg::SP_IDX_FLAGS) |=> slave_port_irq_flag) else $error("flag lost");
  irq_gate_a: assert property (
    !slave_port_irq_enable && (irqStat & irqMask) == '0 |-> !irq) else $error("irq leak");
  drive_only_a: assert property (mode && portDOen == 8'h00 |-> $past(rdAct))
    else $error("bad drive");
  cs_ignore_a: assert property (strb.cs |-> !rdAct && !wrAct) else $error("cs ignored");
  done_edge_a: assert property (wrDone |-> $past(wrAct) && (strb.wr || strb.cs))
    else $error("bad done");

  // Pin ownership and the gate in front of the strobes.
  pins_free_a: assert property (mode && !driveReg |-> portDOen == '1)
    else $error("pins driven");
  gpio_dir_a: assert property (!mode |-> portDOen == dirD) else $error("dir ignored");
  drive_end_a: assert property (!rdAct |=> !driveReg) else $error("drive stuck");
  strobe_gate_a: assert property (!strobesOk |-> !rdAct && !wrAct)
    else $error("gate open");

  // The incoming word is frozen while unread; that is what keeps the first
  // word on overflow, at the price of losing the second one.
  in_keep_a: assert property (in_buf_full |=> $stable(inLatch)) else $error("word replaced");
  ibf_ro_a: assert property (!in_buf_full && !wrDone |=> !in_buf_full) else $error("ibf set by cpu");
  obf_ro_a: assert property (!out_buf_full && !cpuWrData |=> !out_buf_full) else $error("obf set alone");
  ovf_hold_a: assert property (in_buf_overflow && !(wEn && wIdx == sp_pkg::SP_IDX_CTRL) |=> in_buf_overflow)
    else $error("overflow lost");
  irq_raise_a: assert property (slave_port_irq_flag && slave_port_irq_enable |-> irq) else $error("irq missing");
  slave_port_irq_flag_clear_a: assert property (
    wEn && wIdx == sp_pkg::SP_IDX_FLAGS && !s_axi_wdata[sp_pkg::SP_FLAG_IRQ]
    && !rdDone && !wrDone |=> !slave_port_irq_flag) else $error("flag not cleared");
  ev_wr_a: assert property (wrDone |=> irqStat[sp_pkg::SP_EV_WR]) else $error("event lost");
  ev_ovf_a: assert property (ovfSet |=> irqStat[sp_pkg::SP_EV_OVF]) else $error("ovf lost");

  // Register bus: one answer per request, one cycle after it is taken,
  // held until the master accepts it.
  wr_answer_a: assert property (wrFire |=> s_axi_bvalid) else $error("no write answer");
  rd_answer_a: assert property (rdFire |=> s_axi_rvalid) else $error("no read answer");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved");
  wr_refuse_a: assert property (wrFire && !wMapped |=> s_axi_bresp == sp_pkg::SP_RESP_SLVERR)
    else $error("unmapped write accepted");
  rd_refuse_a: assert property (rdFire && !rMapped |=>
    s_axi_rresp == sp_pkg::SP_RESP_SLVERR && s_axi_rdata == '0) else $error("unmapped read");

  // CPU access to the two latches that share the data address.
  out_latch_a: assert property (cpuWrData |=> outLatch == $past(s_axi_wdata[7:0]))
    else $error("store lost");
  in_read_a: assert property (cpuRdData |=> s_axi_rdata[7:0] == $past(inLatch))
    else $error("wrong word read");
  stat_clear_a: assert property (rdFire && rMapped && rIdx == sp_pkg::SP_IDX_IRQ_STAT
    && !rdDone && !wrDone |=> irqStat == '0) else $error("status kept");

  wr_done_c: cover property (wrDone);
  rd_done_c: cover property (rdDone);
  overflow_c: cover property (ovfSet);
  irq_c: cover property (irq);
  gpio_read_c: cover property (rdFire && !mode && rIdx == sp_pkg::SP_IDX_DATA);

endmodule : sp_slave_port
`default_nettype wire

// ===== test/sp_ext_cpu.sv
/*
  Behavioural model of the external processor on the parallel slave port.
  Assumes core_clk paces its strobes and that strobes idle high.
*/
`timescale 1ns/100ps
`default_nettype none
module sp_ext_cpu (
  input wire logic core_clk,
  input wire logic [7:0] portDOut,
  input wire logic [7:0] portDOen,
  output logic [7:0] portDIn,
  output logic [2:0] portEIn = 3'h7
);
  logic [7:0] dat = 8'h00;
  logic drv = 1'b0;

  // A released bus shows the inverse of the last word so stale data never passes as valid.
  assign portDIn = (~portDOen & portDOut) | (portDOen & (drv ? dat : ~dat));

  // Write strobe low with select at cs, data held one clock past the strobe rise.
  task automatic ext_write(input logic [7:0] d, input logic cs);
    @(posedge core_clk);
    dat <= d;
    drv <= 1'b1;
    portEIn <= {cs, 2'b01};
    repeat (6) @(posedge core_clk);
    portEIn <= 3'h7;
    @(posedge core_clk);
    drv <= 1'b0;
    repeat (10) @(posedge core_clk);
  endtask : ext_write

  // Read strobe low under select; the word is taken just before the strobe rises.
  task automatic ext_read(output logic [7:0] d);
    @(posedge core_clk);
    portEIn <= 3'b010;
    repeat (8) @(posedge core_clk);
    d = portDIn;
    portEIn <= 3'h7;
    repeat (10) @(posedge core_clk);
  endtask : ext_read
endmodule : sp_ext_cpu
`default_nettype wire

// ===== test/tb_top.sv
/*
  Self-checking bench of the parallel slave port over AXI4-Lite.
  Assumes sp_pkg, the design and the external processor model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] portDIn, portDOut, portDOen, d1, d2, d3, got;
  logic [2:0] portEIn, portEOut, portEOen;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  localparam logic [1:0] OK = sp_pkg::SP_RESP_OKAY;

  // Free-running core clock.
  always #20 core_clk = ~core_clk;

  sp_slave_port dut (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .portDIn(portDIn), .portDOut(portDOut), .portDOen(portDOen),
    .portEIn(portEIn), .portEOut(portEOut), .portEOen(portEOen), .irq(irq));

  sp_ext_cpu ext (.core_clk(core_clk), .portDOut(portDOut), .portDOen(portDOen),
    .portDIn(portDIn), .portEIn(portEIn));

  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp(input logic [33:0] exp, input logic [33:0] act);
    cmp_count++;
    if (act !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask : cmp

  task automatic cmp_pin(input logic [7:0] exp, input logic [7:0] act);
    cmp({26'h0, exp}, {26'h0, act});
  endtask : cmp_pin

  // Bounded wait; a hang counts as a mismatch and ends the run.
  task automatic wait_hi(ref logic s);
    int n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (n > 300) begin
        error_cnt++;
        report_and_stop();
      end
    end while (s !== 1'b1);
  endtask : wait_hi

  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ad

  // Each call first lets an edge pass, so a ready lowered by the last call is
  // never raised again in the same time step.
  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r);
    @(posedge core_clk);
    bq.push_back(r);
    awaddr <= ad(idx);
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    wait_hi(awready);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wait_hi(bvalid);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r);
    @(posedge core_clk);
    rq.push_back({r, 24'h0, d});
    araddr <= ad(idx);
    arvalid <= 1'b1;
    rready <= 1'b1;
    wait_hi(arready);
    arvalid <= 1'b0;
    wait_hi(rvalid);
    rready <= 1'b0;
  endtask : axi_rd

  // Responses are matched against the oldest note at the edge that completes them.
  always @(posedge core_clk) begin
    if (bvalid && bready) cmp({32'h0, bq.pop_front()}, {32'h0, bresp});
    if (rvalid && rready) cmp(rq.pop_front(), {rresp, rdata});
  end

  // Main sequence.
  initial begin
    void'($urandom(78171));
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    d3 = 8'($urandom);
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    axi_rd(sp_pkg::SP_IDX_CTRL, 8'h07, OK);
    axi_rd(sp_pkg::SP_IDX_FLAGS, 8'h00, OK);
    axi_rd(sp_pkg::SP_IDX_EN, 8'h00, OK);
    $display("Test reset values done");
    axi_wr(sp_pkg::SP_IDX_CTRL, 8'h17, OK);
    cmp_pin(8'h07, {5'h0, portEOen});
    axi_wr(sp_pkg::SP_IDX_DATA, d1, OK);
    axi_rd(sp_pkg::SP_IDX_CTRL, 8'h57, OK);
    cmp_pin(8'hff, portDOen);
    ext.ext_read(got);
    cmp_pin(d1, got);
    axi_rd(sp_pkg::SP_IDX_CTRL, 8'h17, OK);
    axi_rd(sp_pkg::SP_IDX_FLAGS, 8'h80, OK);
    $display("Test outgoing latch done");
    ext.ext_write(d2, 1'b0);
    axi_rd(sp_pkg::SP_IDX_CTRL, 8'h97, OK);
    ext.ext_write(d3, 1'b0);
    axi_rd(sp_pkg::SP_IDX_CTRL, 8'hb7, OK);
    axi_rd(sp_pkg::SP_IDX_DATA, d2, OK);
    axi_rd(sp_pkg::SP_IDX_CTRL, 8'h37, OK);
    ext.ext_write(d3, 1'b0);
    axi_rd(sp_pkg::SP_IDX_IRQ_STAT, 8'h07, OK);
    axi_wr(sp_pkg::SP_IDX_CTRL, 8'h27, OK);
    axi_rd(sp_pkg::SP_IDX_CTRL, 8'h27, OK);
    axi_rd(sp_pkg::SP_IDX_DATA, ~d3, OK);
    axi_rd(sp_pkg::SP_IDX_DIR_D, 8'hff, OK);
    axi_wr(sp_pkg::SP_IDX_CTRL, 8'h17, OK);
    axi_rd(sp_pkg::SP_IDX_CTRL, 8'h17, OK);
    $display("Test incoming latch done");
    axi_wr(sp_pkg::SP_IDX_EN, 8'h80, OK);
    cmp_pin(8'h01, {7'h0, irq});
    axi_wr(sp_pkg::SP_IDX_EN, 8'h00, OK);
    cmp_pin(8'h00, {7'h0, irq});
    axi_wr(sp_pkg::SP_IDX_FLAGS, 8'h00, OK);
    axi_rd(sp_pkg::SP_IDX_FLAGS, 8'h00, OK);
    axi_wr(sp_pkg::SP_IDX_IRQ_MASK, 8'h02, OK);
    ext.ext_write(d1, 1'b0);
    cmp_pin(8'h01, {7'h0, irq});
    axi_rd(sp_pkg::SP_IDX_IRQ_STAT, 8'h02, OK);
    cmp_pin(8'h00, {7'h0, irq});
    axi_rd(sp_pkg::SP_IDX_DATA, d1, OK);
    $display("Test interrupt done");
    ext.ext_write(d2, 1'b1);
    axi_rd(sp_pkg::SP_IDX_CTRL, 8'h17, OK);
    axi_wr(sp_pkg::SP_IDX_CTRL, 8'h16, OK);
    ext.ext_write(d2, 1'b0);
    cmp_pin(8'h06, {5'h0, portEOen});
    wstrb <= 4'h0;
    axi_wr(sp_pkg::SP_IDX_DATA, d3, OK);
    wstrb <= 4'hf;
    axi_rd(sp_pkg::SP_IDX_CTRL, 8'h16, OK);
    axi_rd(sp_pkg::SP_IDX_IRQ_STAT, 8'h00, OK);
    axi_wr(sp_pkg::SP_IDX_PINS, 8'h05, OK);
    cmp_pin(8'h05, {5'h0, portEOut});
    axi_rd(sp_pkg::SP_IDX_PINS, 8'h07, OK);
    axi_wr(8'h3f, d1, sp_pkg::SP_RESP_SLVERR);
    axi_rd(8'h3f, 8'h00, sp_pkg::SP_RESP_SLVERR);
    $display("Test refusals done");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
